// [verilog/iepr_regs.sv]
// Function
// RQ1: timer0 priority at base bit one
// RQ2: external irq0 priority at base bit zero
// RQ3: extended enable register, reset zero
// RQ4: extended priority register, reset zero
// RQ5: unused base bits read one, ignore writes
// RQ6: reserved extended bits have no effect
`timescale 1ns/1ps
`include "iepr_params.svh"
module iepr_regs (
	input  wire logic            core_clk,
	input  wire logic            rst,
	input  wire logic [7:0]      sfr_addr,
	input  wire logic            sfr_wr,
	input  wire iepr_pkg::iepr_byte_t sfr_wdata,
	input  wire logic            sfr_rd,
	output iepr_pkg::iepr_byte_t sfr_rdata,
	output logic                 sfr_hit,
	output logic                 timer0_prio,
	output logic                 ext_irq0_prio,
	output logic                 timer3_irq_en,
	output logic                 comparator_irq_en,
	output logic                 counter_array_irq_en,
	output logic                 converter_irq_en,
	output logic                 mgmt_bus_irq_en,
	output logic                 timer3_prio,
	output logic                 comparator_prio,
	output logic                 counter_array_prio,
	output logic                 converter_prio,
	output logic                 mgmt_bus_prio
);
	import iepr_pkg::*;
	// ----------------------------------------------------------------
	// storage
	// ----------------------------------------------------------------
	logic [1:0] base_bits;			// implemented base priority bits
	logic [1:0] next_base_bits;		// next base bits
	iepr_byte_t ext_en;			// implemented enable bits only
	iepr_byte_t next_ext_en;		// next enable
	iepr_byte_t ext_prio;			// implemented priority bits only
	iepr_byte_t next_ext_prio;		// next priority
	iepr_byte_t next_rdata;			// next read data
	logic       next_hit;			// next address hit

	// ----------------------------------------------------------------
	// write decode
	// ----------------------------------------------------------------
	// decode writes; reserved bits are masked so they steer nothing
	// dropping them here means no later logic can ever see them, which
	// costs a mask on each of the two extended write paths but keeps every consumer free of masking
	always_comb begin
		next_base_bits = base_bits;
		next_ext_en    = ext_en;
		next_ext_prio  = ext_prio;
		if (sfr_wr && sfr_addr == `IEPR_BASE_PRIO_ADDR) begin
			next_base_bits = sfr_wdata[1:0];	// RQ1 RQ2 RQ5
		end
		if (sfr_wr && sfr_addr == `IEPR_EXT_EN_ADDR) begin
			next_ext_en = sfr_wdata & `IEPR_EXT_IMPL_MASK;	// RQ3 RQ6
		end
		if (sfr_wr && sfr_addr == `IEPR_EXT_PRIO_ADDR) begin
			next_ext_prio = sfr_wdata & `IEPR_EXT_IMPL_MASK;	// RQ4 RQ6
		end
	end

	// ----------------------------------------------------------------
	// read path
	// ----------------------------------------------------------------
	// read mux; unused base bits always read as one
	// the mux looks at the next values so that a read in the same cycle
	// as a write to the same address returns the freshly written byte
	always_comb begin
		next_rdata = 8'h00;
		next_hit   = 1'b0;
		if (sfr_rd) begin
			case (sfr_addr)
				`IEPR_BASE_PRIO_ADDR: begin
					// upper six bits are constant ones
					next_rdata = `IEPR_BASE_ONES
						| {6'h00, next_base_bits};	// RQ5
					next_hit   = 1'b1;
				end
				`IEPR_EXT_EN_ADDR: begin
					next_rdata = next_ext_en;
					next_hit   = 1'b1;
				end
				`IEPR_EXT_PRIO_ADDR: begin
					next_rdata = next_ext_prio;
					next_hit   = 1'b1;
				end
				default: begin
					next_rdata = 8'h00;	// unmapped reads zero
					next_hit   = 1'b0;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// registers; outputs come straight from flops
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (rst) begin
			base_bits <= `IEPR_BASE_RESET;
			ext_en    <= `IEPR_EXT_RESET;	// RQ3
			ext_prio  <= `IEPR_EXT_RESET;	// RQ4
			sfr_rdata <= 8'h00;
			sfr_hit   <= 1'b0;
		end else begin
			base_bits <= next_base_bits;
			ext_en    <= next_ext_en;
			ext_prio  <= next_ext_prio;
			sfr_rdata <= next_rdata;
			sfr_hit   <= next_hit;
		end
	end

	// ----------------------------------------------------------------
	// field outputs
	// ----------------------------------------------------------------
	// field outputs are wires from the stored bits, so each one is a
	// flop output with no logic between it and the pin
	assign timer0_prio          = base_bits[`IEPR_TMR0_BIT];	// RQ1
	assign ext_irq0_prio        = base_bits[`IEPR_EXT0_BIT];	// RQ2
	assign timer3_irq_en        = ext_en[`IEPR_TMR3_BIT];
	assign comparator_irq_en    = ext_en[`IEPR_COMP_BIT];
	assign counter_array_irq_en = ext_en[`IEPR_CNTA_BIT];
	assign converter_irq_en     = ext_en[`IEPR_CONV_BIT];
	assign mgmt_bus_irq_en      = ext_en[`IEPR_MGMT_BIT];
	assign timer3_prio          = ext_prio[`IEPR_TMR3_BIT];
	assign comparator_prio      = ext_prio[`IEPR_COMP_BIT];
	assign counter_array_prio   = ext_prio[`IEPR_CNTA_BIT];
	assign converter_prio       = ext_prio[`IEPR_CONV_BIT];
	assign mgmt_bus_prio        = ext_prio[`IEPR_MGMT_BIT];

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	// timer0 priority follows bit one of a base write
	tmr0_write_a: assert property ( // RQ1
		@(posedge core_clk) disable iff (rst)
		sfr_wr && sfr_addr == `IEPR_BASE_PRIO_ADDR
		|=> timer0_prio == $past(sfr_wdata[1]))
		else $error("timer0 priority not written");
	// external irq0 priority follows bit zero of a base write
	ext0_write_a: assert property ( // RQ2
		@(posedge core_clk) disable iff (rst)
		sfr_wr && sfr_addr == `IEPR_BASE_PRIO_ADDR
		|=> ext_irq0_prio == $past(sfr_wdata[0]))
		else $error("ext irq0 priority not written");
	// outer enable bits land one cycle after the write
	en_write_a: assert property ( // RQ3
		@(posedge core_clk) disable iff (rst)
		sfr_wr && sfr_addr == `IEPR_EXT_EN_ADDR
		|=> timer3_irq_en == $past(sfr_wdata[7])
		&& mgmt_bus_irq_en == $past(sfr_wdata[0]))
		else $error("enable register not written");
	// middle enable bits land one cycle after the write
	mid_en_a: assert property ( // RQ3
		@(posedge core_clk) disable iff (rst)
		sfr_wr && sfr_addr == `IEPR_EXT_EN_ADDR
		|=> comparator_irq_en == $past(sfr_wdata[5])
		&& counter_array_irq_en == $past(sfr_wdata[4])
		&& converter_irq_en == $past(sfr_wdata[3]))
		else $error("middle enable bits not written");
	// some priority bits land one cycle after the write
	prio_write_a: assert property ( // RQ4
		@(posedge core_clk) disable iff (rst)
		sfr_wr && sfr_addr == `IEPR_EXT_PRIO_ADDR
		|=> converter_prio == $past(sfr_wdata[3])
		&& comparator_prio == $past(sfr_wdata[5]))
		else $error("priority register not written");
	// the remaining priority bits land one cycle after the write
	rest_prio_a: assert property ( // RQ4
		@(posedge core_clk) disable iff (rst)
		sfr_wr && sfr_addr == `IEPR_EXT_PRIO_ADDR
		|=> timer3_prio == $past(sfr_wdata[7])
		&& counter_array_prio == $past(sfr_wdata[4])
		&& mgmt_bus_prio == $past(sfr_wdata[0]))
		else $error("remaining priority bits not written");
	// stored enable byte never holds a reserved bit
	en_mask_a: assert property ( // RQ3 RQ6
		@(posedge core_clk) disable iff (rst)
		sfr_wr && sfr_addr == `IEPR_EXT_EN_ADDR
		|=> ext_en == ($past(sfr_wdata) & `IEPR_EXT_IMPL_MASK))
		else $error("enable byte stored a reserved bit");
	// stored priority byte never holds a reserved bit
	prio_mask_a: assert property ( // RQ4 RQ6
		@(posedge core_clk) disable iff (rst)
		sfr_wr && sfr_addr == `IEPR_EXT_PRIO_ADDR
		|=> ext_prio == ($past(sfr_wdata) & `IEPR_EXT_IMPL_MASK))
		else $error("priority byte stored a reserved bit");
	// unused base bits read as ones on every base read
	base_ones_a: assert property ( // RQ5
		@(posedge core_clk) disable iff (rst)
		sfr_rd && sfr_addr == `IEPR_BASE_PRIO_ADDR
		|=> sfr_rdata[7:2] == 6'h3F && sfr_hit)
		else $error("unused base bits not read as one");
	// a base write and read together return the written low bits
	base_wr_rd_a: assert property ( // RQ5
		@(posedge core_clk) disable iff (rst)
		sfr_wr && sfr_rd && sfr_addr == `IEPR_BASE_PRIO_ADDR
		|=> sfr_rdata == {6'h3F, $past(sfr_wdata[1:0])})
		else $error("base write and read disagree");
	// reserved extended bits always read back as zero
	resv_zero_a: assert property ( // RQ6
		@(posedge core_clk) disable iff (rst)
		sfr_rd && (sfr_addr == `IEPR_EXT_EN_ADDR
		|| sfr_addr == `IEPR_EXT_PRIO_ADDR)
		|=> sfr_rdata[6] == 1'b0 && sfr_rdata[2:1] == 2'h0)
		else $error("reserved bit stored");
	// read data and hit are zero in any cycle that follows no read
	idle_read_a: assert property (
		@(posedge core_clk) disable iff (rst)
		!sfr_rd |=> sfr_rdata == 8'h00 && !sfr_hit)
		else $error("read data shown without a read");
	// unmapped addresses read zero and give no hit
	miss_read_a: assert property (
		@(posedge core_clk) disable iff (rst)
		sfr_rd && sfr_addr != `IEPR_BASE_PRIO_ADDR
		&& sfr_addr != `IEPR_EXT_EN_ADDR
		&& sfr_addr != `IEPR_EXT_PRIO_ADDR
		|=> sfr_rdata == 8'h00 && !sfr_hit)
		else $error("unmapped read answered");
	// both extended bytes come out of reset cleared
	reset_val_a: assert property ( // RQ3 RQ4
		@(posedge core_clk)
		$past(rst) |-> ext_en == 8'h00 && ext_prio == 8'h00)
		else $error("extended registers not reset");
	// nothing moves the extended bytes but a write
	hold_a: assert property ( // RQ4
		@(posedge core_clk) disable iff (rst)
		!sfr_wr |=> $stable(ext_prio) && $stable(ext_en))
		else $error("register changed without write");
endmodule : iepr_regs

// [pkg/iepr_params.svh]
`ifndef IEPR_PARAMS_SVH
`define IEPR_PARAMS_SVH
// ----------------------------------------------------------------
// special-function register addresses
// ----------------------------------------------------------------
`define IEPR_BASE_PRIO_ADDR 8'hB8
`define IEPR_EXT_EN_ADDR 8'hE6
`define IEPR_EXT_PRIO_ADDR 8'hF6
// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define IEPR_EXT0_BIT 0
`define IEPR_TMR0_BIT 1
`define IEPR_MGMT_BIT 0
`define IEPR_CONV_BIT 3
`define IEPR_CNTA_BIT 4
`define IEPR_COMP_BIT 5
`define IEPR_TMR3_BIT 7
// ----------------------------------------------------------------
// masks and reset values
// ----------------------------------------------------------------
`define IEPR_EXT_IMPL_MASK 8'hB9
`define IEPR_BASE_ONES 8'hFC
`define IEPR_EXT_RESET 8'h00
`define IEPR_BASE_RESET 2'h0
`endif

// [pkg/iepr_pkg.sv]
// ----------------------------------------------------------------
// shared types
// ----------------------------------------------------------------
package iepr_pkg;
	typedef logic [7:0] iepr_byte_t;	// one register byte
endpackage : iepr_pkg

// [tb/test_interrupt_enable_priority_regs.sv]
`timescale 1ns/1ps
`include "iepr_params.svh"
// ----------------------------------------------------------------
// register bench: driver notes expectations, monitor compares them
// ----------------------------------------------------------------
module test_interrupt_enable_priority_regs;
	import iepr_pkg::*;
	logic core_clk = 1'b0, rst = 1'b1, sfr_wr = 1'b0, sfr_rd = 1'b0;
	logic [7:0] sfr_addr = 8'h00;	// register address
	iepr_byte_t sfr_wdata = 8'h00, sfr_rdata, ee = 8'h00, ep = 8'h00;
	logic [1:0] bp = 2'h0;	// model of base priority low bits
	logic sfr_hit, pend = 1'b0;	// pend: a read result is due
	logic timer0_prio, ext_irq0_prio, timer3_irq_en, comparator_irq_en;
	logic counter_array_irq_en, converter_irq_en, mgmt_bus_irq_en;
	logic timer3_prio, comparator_prio, counter_array_prio;
	logic converter_prio, mgmt_bus_prio;
	logic [20:0] notes[$];	// {hit, rdata, fields} per read
	logic [7:0] adr[4] = '{`IEPR_BASE_PRIO_ADDR, `IEPR_EXT_EN_ADDR,
		`IEPR_EXT_PRIO_ADDR, 8'h5A};	// last one is unmapped
	logic [31:0] rv;
	logic [20:0] got;	// observed result, same layout as a note
	int num_errors = 0, n_tests = 0;
	iepr_regs i_dut (.core_clk, .rst, .sfr_addr, .sfr_wr, .sfr_wdata,
		.sfr_rd, .sfr_rdata, .sfr_hit, .timer0_prio, .ext_irq0_prio,
		.timer3_irq_en, .comparator_irq_en, .counter_array_irq_en,
		.converter_irq_en, .mgmt_bus_irq_en, .timer3_prio,
		.comparator_prio, .counter_array_prio, .converter_prio,
		.mgmt_bus_prio);
	initial begin	// 25 ns period
		forever #12.5 core_clk = ~core_clk;
	end
	task automatic wrap_up;
		$display("errors %0d compares %0d", num_errors, n_tests);
		if (num_errors == 0 && n_tests > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : wrap_up
	task automatic chk(input logic [20:0] exp, input logic [20:0] got);
		n_tests++;
		if (exp !== got) begin
			num_errors++;
			$display("Error t=%0t exp=%h got=%h", $time, exp, got);
		end
	endtask : chk
	// one bus cycle, set at the falling edge; model updated first so a
	// read in the same cycle as a write expects the new value
	task automatic op(input logic w, input logic r, input logic [7:0] a,
		input logic [7:0] d);
		@(negedge core_clk);
		{sfr_wr, sfr_rd, sfr_addr, sfr_wdata} = {w, r, a, d};
		if (w && a == `IEPR_EXT_EN_ADDR) ee = d & `IEPR_EXT_IMPL_MASK;
		if (w && a == `IEPR_EXT_PRIO_ADDR) ep = d & `IEPR_EXT_IMPL_MASK;
		if (w && a == `IEPR_BASE_PRIO_ADDR) bp = d[1:0];
		if (r) notes.push_back({a == adr[0] || a == adr[1] || a == adr[2],
			a == adr[1] ? ee : a == adr[2] ? ep : a == adr[0] ?
			{6'h3F, bp} : 8'h00, bp, ee[7], ee[5], ee[4], ee[3], ee[0],
			ep[7], ep[5], ep[4], ep[3], ep[0]});
	endtask : op
	task automatic do_reset(input int n);
		@(negedge core_clk);
		{rst, sfr_wr, sfr_rd} = 3'h4;
		repeat (n) @(negedge core_clk);
		{rst, ee, ep, bp} = '0;
	endtask : do_reset
	// monitor: a result is due the cycle after a taken read
	always @(posedge core_clk) pend <= sfr_rd & ~rst;
	always @(negedge core_clk) begin
		got = {sfr_hit, sfr_rdata, timer0_prio, ext_irq0_prio,
			timer3_irq_en, comparator_irq_en, counter_array_irq_en,
			converter_irq_en, mgmt_bus_irq_en, timer3_prio,
			comparator_prio, counter_array_prio, converter_prio,
			mgmt_bus_prio};
		if (pend && notes.size() > 0) begin
			chk(notes.pop_front(), got);
		end else if (pend) begin
			num_errors++;	// a result with no note behind it
		end
	end
	initial begin	// watchdog: a hang counts as a mismatch
		repeat (5000) @(posedge core_clk);
		num_errors++;
		wrap_up;
	end
	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		void'($urandom(32'hf3dc));
		do_reset(5);
		for (int k = 0; k < 4; k++) op(1'b0, 1'b1, adr[k], 8'h00);
		for (int k = 0; k < 4; k++) begin	// all ones, readback, then write 46 and read in the same cycle
			op(1'b1, 1'b0, adr[k], 8'hFF);
			op(1'b0, 1'b1, adr[k], 8'h00);
			op(1'b1, 1'b1, adr[k], 8'h46);
		end
		repeat (80) begin	// random back-to-back traffic
			rv = $urandom;
			op(rv[0], rv[1], adr[rv[3:2]], rv[15:8]);
		end
		do_reset(2);	// reset in mid-run clears every field
		for (int k = 0; k < 3; k++) op(1'b0, 1'b1, adr[k], 8'h00);
		op(1'b0, 1'b0, 8'h00, 8'h00);
		for (int k = 0; k < 10 && notes.size() > 0; k++) @(negedge core_clk);
		if (notes.size() > 0) num_errors++;
		wrap_up;
	end
endmodule : test_interrupt_enable_priority_regs
